//--- hw/fpr_pkg.sv
// fpr_pkg: constants, types and decode for the fan duty floor and ramp logic
// What this block does
// - channel two below threshold: floor duty or off
// - bit 7 picks channel three floor or off
// - lock set: acoustic register writes ignored
// - slow-ramp bit makes ramp four times slower
// - local-channel changes ramp, never jump
// - normal table: increments 1,2,3,4,8,12,24,48
// - long table: code 0 52.2s, code 1 26.1s
// - ramp rate register resets to zero
// - long table: codes 2..4 give 17.4/10.4/6.5s
package fpr_pkg;

  // register offsets and reset values
  localparam logic [7:0] ADDR_FLOOR_SEL = 8'h62;
  localparam logic [7:0] ADDR_RAMP      = 8'h63;
  localparam logic [7:0] FLOOR_SEL_RST  = 8'h00;
  localparam logic [7:0] RAMP_RST       = 8'h00;

  // field positions
  localparam int CH2_HOLD_BIT   = 6;
  localparam int CH3_HOLD_BIT   = 7;
  localparam int RAMP_LSB       = 0;
  localparam int RAMP_W         = 3;
  localparam int CFG6_LONG_BIT  = 7;
  localparam int CFG6_SLOW_BIT  = 2;
  localparam logic [1:0] SLOW_Q_LAST = 2'h3;  // four base slots per slow slot

  // code three runs a four-fifths slot in both tables, which gives it the
  // 7.5 s and 10.4 s sweeps that increment four alone would miss
  localparam logic [2:0]  CODE3     = 3'h3;
  localparam int unsigned CODE3_NUM = 32'd4;
  localparam int unsigned CODE3_DEN = 32'd5;

  // slot timing, derived from the full-scale sweep at increment one
  localparam longint unsigned CLK_MHZ       = 64'd100;
  localparam longint unsigned CYC_PER_MS    = CLK_MHZ * 64'd1000;
  localparam longint unsigned SWEEP_NORM_MS = 64'd37500;
  localparam longint unsigned SWEEP_LONG_MS = 64'd52200;
  localparam longint unsigned FULL_STEPS    = 64'd255;
  localparam int unsigned SLOT_NORM_CYC = 32'(SWEEP_NORM_MS * CYC_PER_MS / FULL_STEPS);
  localparam int unsigned SLOT_LONG_CYC = 32'(SWEEP_LONG_MS * CYC_PER_MS / FULL_STEPS);

  // one pwm channel as handed over by the automatic control loop
  typedef struct packed {
    logic [7:0] target;    // loop target duty
    logic [7:0] min_duty;  // programmed minimum duty
    logic       below;     // temperature below start temperature minus hysteresis
  } fpr_chan_t;

  typedef struct packed {
    logic [31:0]     cnt;
    logic [1:0]      q;
    logic [7:0]      below_threshold_duty_select;
    logic [7:0]      local_channel_ramp_rate;
    logic [7:0]      rdata;
    logic [1:0][7:0] duty;
  } fpr_state_t;

  // ramp code to duty increment per time slot
  function automatic logic [7:0] fpr_incr(input logic [2:0] code);
    logic [7:0] inc;
    inc = 8'h01;
    unique case (code)
      3'h0: inc = 8'h01;
      3'h1: inc = 8'h02;
      3'h2: inc = 8'h03;
      3'h3: inc = 8'h04;
      3'h4: inc = 8'h08;
      3'h5: inc = 8'h0c;
      3'h6: inc = 8'h18;
      3'h7: inc = 8'h30;
    endcase
    return inc;
  endfunction

endpackage

//--- hw/fpr_ramp_step.sv
// fpr_ramp_step: next duty of one channel, jump or bounded step toward target
`timescale 1ns/10ps
module fpr_ramp_step (
  input  wire logic [7:0] cur_i,
  input  wire logic [7:0] tgt_i,
  input  wire logic [7:0] incr_i,
  input  wire logic       ramp_i,
  input  wire logic       tick_i,
  output logic      [7:0] nxt_o
);

  logic [7:0] gap_up;
  logic [7:0] gap_dn;

  // distance to target in each direction
  assign gap_up = tgt_i - cur_i;
  assign gap_dn = cur_i - tgt_i;

  // step by at most the increment, landing exactly on the target
  always_comb begin
    nxt_o = cur_i;
    if (!ramp_i) begin
      nxt_o = tgt_i;  // non-local changes take effect at once
    end else if (tick_i) begin
      if (tgt_i > cur_i) begin
        nxt_o = (gap_up <= incr_i) ? tgt_i : cur_i + incr_i;
      end else if (tgt_i < cur_i) begin
        nxt_o = (gap_dn <= incr_i) ? tgt_i : cur_i - incr_i;
      end
    end
  end

endmodule

//--- hw/fpr_top.sv
// fpr_top: duty floor selection and local-channel ramp for fan outputs two and three
`timescale 1ns/10ps
module fpr_top #(
  parameter int unsigned SLOT_NORM = fpr_pkg::SLOT_NORM_CYC,
  parameter int unsigned SLOT_LONG = fpr_pkg::SLOT_LONG_CYC
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     ce_i,
  input  wire logic [7:0]               reg_addr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic                     cfg_lock_i,
  input  wire logic [7:0]               cfg6_i,
  input  wire logic                     auto_mode_i,
  input  wire logic                     local_ctrl_i,
  input  fpr_pkg::fpr_chan_t [1:0]      chan_i,
  output logic [7:0]                    rdata_o,
  output logic [7:0]                    fan_output_two_o,
  output logic [7:0]                    fan_output_three_o
);

  // shortened slot lengths for ramp code three
  localparam int unsigned SLOT_NORM3 = SLOT_NORM * fpr_pkg::CODE3_NUM / fpr_pkg::CODE3_DEN;
  localparam int unsigned SLOT_LONG3 = SLOT_LONG * fpr_pkg::CODE3_NUM / fpr_pkg::CODE3_DEN;

  fpr_pkg::fpr_state_t s_r;
  fpr_pkg::fpr_state_t s_nxt;
  logic [31:0]         slot_len;
  logic                base_tick;
  logic                slow;
  logic                tick;
  logic [7:0]          incr;
  logic [1:0]          hold;
  logic [1:0][7:0]     eff;
  logic [1:0][7:0]     step_nxt;
  logic                wr_ok;
  logic [2:0]          code;
  logic                long_tbl;
  logic                short3;

  // slot length follows the table select bit and the code, slow bit stretches by four
  assign code      = s_r.local_channel_ramp_rate[fpr_pkg::RAMP_LSB +: fpr_pkg::RAMP_W];
  assign long_tbl  = cfg6_i[fpr_pkg::CFG6_LONG_BIT];
  assign short3    = (code == fpr_pkg::CODE3);
  assign slot_len  = long_tbl ? (short3 ? SLOT_LONG3 : SLOT_LONG)
                              : (short3 ? SLOT_NORM3 : SLOT_NORM);
  assign base_tick = ce_i && (s_r.cnt >= slot_len - 32'h1);
  assign slow      = cfg6_i[fpr_pkg::CFG6_SLOW_BIT];
  assign tick      = base_tick && (!slow || (s_r.q == fpr_pkg::SLOW_Q_LAST));
  assign incr      = fpr_pkg::fpr_incr(code);
  assign wr_ok     = ce_i && reg_wr_i && !cfg_lock_i;

  // floor bits per channel
  assign hold[0] = s_r.below_threshold_duty_select[fpr_pkg::CH2_HOLD_BIT];
  assign hold[1] = s_r.below_threshold_duty_select[fpr_pkg::CH3_HOLD_BIT];

  // effective target and step per channel
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign eff[i] = (auto_mode_i && chan_i[i].below) ?
                    (hold[i] ? chan_i[i].min_duty : 8'h00) : chan_i[i].target;
    fpr_ramp_step u_step (
      .cur_i  (s_r.duty[i]),
      .tgt_i  (eff[i]),
      .incr_i (incr),
      .ramp_i (local_ctrl_i),
      .tick_i (tick),
      .nxt_o  (step_nxt[i])
    );
  end

  // next state: slot counter, register writes, read data, duties
  always_comb begin
    s_nxt = s_r;
    if (ce_i) begin
      if (base_tick) begin
        s_nxt.cnt = 32'h0;
        s_nxt.q   = s_r.q + 2'h1;
      end else begin
        s_nxt.cnt = s_r.cnt + 32'h1;
      end
      if (wr_ok && reg_addr_i == fpr_pkg::ADDR_FLOOR_SEL) begin
        s_nxt.below_threshold_duty_select = reg_wdata_i;
      end
      if (wr_ok && reg_addr_i == fpr_pkg::ADDR_RAMP) begin
        s_nxt.local_channel_ramp_rate = reg_wdata_i;
      end
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          fpr_pkg::ADDR_FLOOR_SEL: s_nxt.rdata = s_r.below_threshold_duty_select;
          fpr_pkg::ADDR_RAMP:      s_nxt.rdata = s_r.local_channel_ramp_rate;
          default:                 s_nxt.rdata = 8'h00;  // unmapped reads zero
        endcase
      end
      s_nxt.duty = step_nxt;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r.cnt                         <= 32'h0;
      s_r.q                           <= 2'h0;
      s_r.below_threshold_duty_select <= fpr_pkg::FLOOR_SEL_RST;
      s_r.local_channel_ramp_rate     <= fpr_pkg::RAMP_RST;
      s_r.rdata                       <= 8'h00;
      s_r.duty                        <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign rdata_o            = s_r.rdata;
  assign fan_output_two_o   = s_r.duty[0];
  assign fan_output_three_o = s_r.duty[1];

  // helpers read only by the checks below
  logic       ramp_written_r;
  logic [7:0] move_mag;
  logic [7:0] move_mag3;

  assign move_mag = (step_nxt[0] > s_r.duty[0]) ? step_nxt[0] - s_r.duty[0]
                                                 : s_r.duty[0] - step_nxt[0];
  assign move_mag3 = (step_nxt[1] > s_r.duty[1]) ? step_nxt[1] - s_r.duty[1]
                                                  : s_r.duty[1] - step_nxt[1];

  // remembers whether the ramp register ever took a write
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ramp_written_r <= 1'b0;
    end else if (wr_ok && reg_addr_i == fpr_pkg::ADDR_RAMP) begin
      ramp_written_r <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_lock_freezes_regs: assert property (
    (ce_i && reg_wr_i && cfg_lock_i) |=> ($stable(s_r.local_channel_ramp_rate)
      && $stable(s_r.below_threshold_duty_select)))
    else $error("locked write changed an acoustic register");

  a_ramp_reset_zero: assert property (
    !ramp_written_r |-> (s_r.local_channel_ramp_rate == 8'h00))
    else $error("ramp register not zero before first write");

  a_ch2_floor_min: assert property (
    (ce_i && auto_mode_i && chan_i[0].below && hold[0] && !local_ctrl_i)
      |=> (fan_output_two_o == $past(chan_i[0].min_duty)))
    else $error("channel two did not hold minimum duty");

  a_ch2_floor_off: assert property (
    (ce_i && auto_mode_i && chan_i[0].below && !hold[0] && !local_ctrl_i)
      |=> (fan_output_two_o == 8'h00))
    else $error("channel two not off below threshold");

  a_ch3_floor_sel: assert property (
    (ce_i && auto_mode_i && chan_i[1].below && !local_ctrl_i)
      |=> (fan_output_three_o == ($past(s_r.below_threshold_duty_select[7]) ?
                                  $past(chan_i[1].min_duty) : 8'h00)))
    else $error("channel three floor selection wrong");

  a_no_jump_local: assert property (
    (ce_i && local_ctrl_i && !tick) |=> $stable(fan_output_two_o))
    else $error("local ramp moved outside a time slot");

  a_step_bounded: assert property (
    (tick && local_ctrl_i) |-> (move_mag <= incr))
    else $error("ramp step exceeded increment");

  a_step_reaches: assert property (
    (tick && local_ctrl_i && $stable(eff[0]) && s_r.duty[0] != eff[0]
      && move_mag != incr) |=> (fan_output_two_o == $past(eff[0])))
    else $error("short step did not land on target");

  a_slow_quarter: assert property (
    (base_tick && slow && s_r.q != fpr_pkg::SLOW_Q_LAST) |-> !tick)
    else $error("slow ramp ticked early");

  a_slot_length: assert property (
    (base_tick && $stable(slot_len)) |-> (s_r.cnt == slot_len - 32'h1))
    else $error("time slot length wrong");

  a_ce_freeze: assert property (
    !ce_i |=> $stable(s_r))
    else $error("state moved while clock enable low");

  a_write_lands: assert property (
    (ce_i && reg_wr_i && !cfg_lock_i && reg_addr_i == fpr_pkg::ADDR_RAMP)
      |=> (s_r.local_channel_ramp_rate == $past(reg_wdata_i)))
    else $error("unlocked ramp write did not land");

  a_read_unmapped: assert property (
    (ce_i && reg_rd_i && reg_addr_i != fpr_pkg::ADDR_FLOOR_SEL
      && reg_addr_i != fpr_pkg::ADDR_RAMP) |=> (rdata_o == 8'h00))
    else $error("unmapped read not zero");

  a_jump_nonlocal: assert property (
    (ce_i && !local_ctrl_i && !auto_mode_i)
      |=> (fan_output_three_o == $past(chan_i[1].target)))
    else $error("non-local change did not take effect at once");

  a_ch3_no_jump: assert property (
    (ce_i && local_ctrl_i && !tick) |=> $stable(fan_output_three_o))
    else $error("channel three moved outside a time slot");

  a_ch3_step_bounded: assert property (
    (tick && local_ctrl_i) |-> (move_mag3 <= incr))
    else $error("channel three step exceeded increment");

  c_local_ramp_up: cover property (tick && local_ctrl_i && eff[0] > s_r.duty[0]);
  c_locked_write:  cover property (ce_i && reg_wr_i && cfg_lock_i);
  c_floor_hold:    cover property (ce_i && auto_mode_i && chan_i[1].below && hold[1]);
  c_slow_tick:     cover property (tick && slow);
  c_code3_long:    cover property (tick && long_tbl && short3);

endmodule

//--- bench/test_fpr_top.sv
// test_fpr_top: self-checking bench for the fan duty floor and local ramp block
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_fpr_top;
  localparam int unsigned SN = 8;
  localparam int unsigned SL = 11;
  localparam int unsigned SN3 = SN * fpr_pkg::CODE3_NUM / fpr_pkg::CODE3_DEN;
  localparam int unsigned SL3 = SL * fpr_pkg::CODE3_NUM / fpr_pkg::CODE3_DEN;
  localparam logic [7:0] INC [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
  logic                          ref_clk_i, rstn_i, ce_i, reg_wr_i, reg_rd_i;
  logic                          cfg_lock_i, auto_mode_i, local_ctrl_i;
  logic [7:0]                    reg_addr_i, reg_wdata_i, cfg6_i;
  fpr_pkg::fpr_chan_t [1:0]      chan_i;
  logic [7:0]                    rdata_o, fan_output_two_o, fan_output_three_o;
  int                            bad_count, checks_done;
  int                            cyc = 0;

  fpr_top #(.SLOT_NORM(SN), .SLOT_LONG(SL)) fpr_top_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .cfg_lock_i(cfg_lock_i), .cfg6_i(cfg6_i), .auto_mode_i(auto_mode_i),
    .local_ctrl_i(local_ctrl_i), .chan_i(chan_i), .rdata_o(rdata_o),
    .fan_output_two_o(fan_output_two_o), .fan_output_three_o(fan_output_three_o));

  // free-running clock, 10 ns period
  always #5 ref_clk_i = ~ref_clk_i;

  // hang guard: a run past the ceiling counts as a mismatch
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // duty after a step, capped at the ramp target
  function automatic logic [7:0] mn(input logic [8:0] a);
    return (a > 9'h060) ? 8'h60 : a[7:0];
  endfunction

  // one register write, strobe held for a single taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // one register read, data sampled 1 ns after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // reset values, plain access, unmapped read, lock and clock enable
  task automatic reg_chk;
    logic [7:0] d;
    rd(8'h63, d); `CHK(d, 8'h00)
    rd(8'h62, d); `CHK(d, 8'h00)
    wr(8'h63, 8'h05); rd(8'h63, d); `CHK(d, 8'h05)
    rd(8'h44, d); `CHK(d, 8'h00)
    @(posedge ref_clk_i) cfg_lock_i <= 1'b1;
    wr(8'h63, 8'h02); rd(8'h63, d); `CHK(d, 8'h05)
    wr(8'h62, 8'hc0); rd(8'h62, d); `CHK(d, 8'h00)
    @(posedge ref_clk_i) cfg_lock_i <= 1'b0;
    @(posedge ref_clk_i) ce_i <= 1'b0;
    wr(8'h63, 8'h07);
    ce_i <= 1'b1;
    rd(8'h63, d); `CHK(d, 8'h05)
  endtask

  // below threshold: each hold-bit pair picks floor duty or off per output
  task automatic floor_chk;
    logic [1:0] s;
    @(posedge ref_clk_i);
    auto_mode_i <= 1'b1; local_ctrl_i <= 1'b0;
    chan_i[0] <= '{8'h90, 8'h21, 1'b1};
    chan_i[1] <= '{8'h90, 8'h32, 1'b1};
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(8'h62, {s, 6'h00});
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK(fan_output_two_o, s[0] ? 8'h21 : 8'h00)
      `CHK(fan_output_three_o, s[1] ? 8'h32 : 8'h00)
    end
    @(posedge ref_clk_i) auto_mode_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK(fan_output_two_o, 8'h90)
  endtask

  // local ramp from 0 toward 0x60: no jump, step size, slot spacing, stop
  task automatic ramp_chk(input logic [2:0] code, input logic [7:0] c6, input int per);
    logic [7:0] inc, prev;
    int n;
    inc = INC[code];
    wr(8'h63, {5'h00, code});
    @(posedge ref_clk_i);
    cfg6_i <= c6; local_ctrl_i <= 1'b0; chan_i[0].target <= 8'h00;
    repeat (2) @(posedge ref_clk_i);
    local_ctrl_i <= 1'b1; chan_i[0].target <= 8'h60;
    @(posedge ref_clk_i);
    #1 `CHK(fan_output_two_o !== 8'h60, 1'b1)
    n = 0;
    while (fan_output_two_o === 8'h00 && n < 200) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    `CHK(fan_output_two_o, mn({1'b0, inc}))
    prev = fan_output_two_o;
    n = 0;
    while (fan_output_two_o === prev && n < 200) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    `CHK(n, per)
    `CHK(fan_output_two_o, mn({inc, 1'b0}))
    repeat (per) @(posedge ref_clk_i);
    #1 `CHK(fan_output_two_o, mn(9'(inc) * 9'h003))
  endtask

  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    ref_clk_i = 1'b0; rstn_i = 1'b0; ce_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    cfg_lock_i = 1'b0; auto_mode_i = 1'b0; local_ctrl_i = 1'b0; reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00; cfg6_i = 8'h00; chan_i = '0;
    bad_count = 0; checks_done = 0;
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    reg_chk();
    floor_chk();
    for (int c = 0; c < 8; c++) ramp_chk(3'(c), 8'h00, (c == 3) ? SN3 : SN);
    ramp_chk(3'h0, 8'h04, 4 * SN);
    ramp_chk(3'h1, 8'h80, SL);
    ramp_chk(3'h3, 8'h80, SL3);
    ramp_chk(3'h4, 8'h84, 4 * SL);
    print_verdict();
  end
endmodule
